// File: src/tpc_defs.vh
// Register map, field positions, reset values and mode codes of the timer block
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// Register indices; the APB byte address is four times the index
`define TPC_IDX_IRQ_FLAGS 10'h00c
`define TPC_IDX_UNIT2_FLAGS 10'h00d
`define TPC_IDX_WIDE_LOW 10'h00e
`define TPC_IDX_WIDE_HIGH 10'h00f
`define TPC_IDX_WIDE_CTRL 10'h010
`define TPC_IDX_PER_COUNT 10'h011
`define TPC_IDX_PER_CTRL 10'h012
`define TPC_IDX_UNIT1_CTRL 10'h017
`define TPC_IDX_UNIT2_CTRL 10'h01d
`define TPC_IDX_IRQ_ENABLES 10'h08c
`define TPC_IDX_PER_LIMIT 10'h092

// Reset values
`define TPC_RST_WIDE_CTRL 8'h00
`define TPC_RST_PER_CTRL 8'h00
`define TPC_RST_PER_COUNT 8'h00
`define TPC_RST_PER_LIMIT 8'hff
`define TPC_RST_FLAGS 8'h00
`define TPC_RST_UNIT_CTRL 8'h00

// Wide timer control fields
`define TPC_WC_ON 0
`define TPC_WC_EXT 1
`define TPC_WC_ASYNC 2
`define TPC_WC_OSC_EN 3
`define TPC_WC_PS_LO 4
`define TPC_WC_MASK 8'h3f

// Period timer control fields
`define TPC_PC_PS_LO 0
`define TPC_PC_ON 2
`define TPC_PC_POST_LO 3
`define TPC_PC_MASK 8'h7f

// Flag bit positions
`define TPC_FL_WIDE_OVF 0
`define TPC_FL_PERIOD 1
`define TPC_FL_UNIT1 2
`define TPC_FL_UNIT2 0

// Unit control fields and mode codes
`define TPC_UC_MASK 8'h3f
`define TPC_UM_OFF 4'h0
`define TPC_UM_CAP_FALL 4'h4
`define TPC_UM_CAP_RISE 4'h5
`define TPC_UM_CAP_RISE4 4'h6
`define TPC_UM_CAP_RISE16 4'h7
`define TPC_UM_CMP_SET 4'h8
`define TPC_UM_CMP_CLR 4'h9
`define TPC_UM_CMP_SOFT 4'ha
`define TPC_UM_CMP_TRIG 4'hb

// Period timer prescale limits (ratio minus one)
`define TPC_PER_PS1 4'h0
`define TPC_PER_PS4 4'h3
`define TPC_PER_PS16 4'hf

`endif

// File: src/tpc_timers.v
// Wide timer, period timer and capture/compare unit mode logic behind an APB slave
`timescale 1ns/100ps
//
// Operation
// (RULE1) Oscillator runs only while its enable bit set
// (RULE2) Trigger mode compare match zeroes wide timer
// (RULE3) Trigger reset never sets wide overflow flag
// (RULE4) Software count write beats coincident trigger reset
// (RULE5) Software uses synchronous modes for trigger resets
// (RULE6) Wide count bytes survive every reset
// (RULE7) Wide control cleared only by power/brown-out reset
// (RULE8) Count byte write clears wide prescaler
// (RULE9) Period timer: 8-bit RW, cleared on reset
// (RULE10) Period prescale 1, 4 or 16
// (RULE11) Count to limit, then wrap to zero
// (RULE12) Period limit RW, reset to all ones
// (RULE13) Postscaler 1..16 sets period flag
// (RULE14) Control bit 2 enables period counting
// (RULE15) Count/control write or reset clears scalers
// (RULE16) Control write leaves period count alone
// (RULE17) Pre-postscaler match offered to serial port
// (RULE18) Mode 0000 switches unit off, idle
// (RULE19) Modes 0100-0111 select capture edge scaling
// (RULE20) Compare set, clear or soft, flag set
// (RULE21) Mode 1011 flags, resets timer, unit two converts
// (RULE22) Modes 11xx: bits 5-4 are duty low bits
`include "tpc_defs.vh"

module tpc_timers (
	input wire I_REF_CLK,
	input wire I_RST,
	input wire I_POR_BOR,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	input wire I_WIDE_EXT_CLK,
	input wire [1:0] I_UNIT_PIN,
	input wire [1:0] I_UNIT_MATCH,
	input wire I_ADC_ENABLE,
	output wire O_SEC_OSC_EN,
	output wire O_PERIOD_MATCH,
	output wire [1:0] O_UNIT_OUT,
	output wire [1:0] O_UNIT_CAPTURE,
	output wire [1:0] O_UNIT_PWM,
	output wire [3:0] O_UNIT_DUTY_LOW,
	output wire O_ADC_START
);

	reg [31:0] prdata_q;
	reg [31:0] prdata_d;
	reg pready_q;
	reg pslverr_q;
	reg hit_d;
	reg [7:0] wide_ctrl_q;
	reg [15:0] wide_cnt_q;
	reg [2:0] wide_pre_q;
	reg wide_ext_prev_q;
	reg [7:0] per_ctrl_q;
	reg [7:0] per_cnt_q;
	reg [7:0] per_limit_q;
	reg [3:0] per_pre_q;
	reg [3:0] per_post_q;
	reg per_match_q;
	reg [7:0] irq_flags_q;
	reg [7:0] irq_flags_d;
	reg unit2_flag_q;
	reg [7:0] irq_en_q;
	reg adc_start_q;
	wire [9:0] idx;
	wire wr;
	wire wr_wide_low;
	wire wr_wide_high;
	wire wr_wide_ctrl;
	wire wr_per_cnt;
	wire wr_per_ctrl;
	wire [1:0] wr_unit;
	wire [1:0] unit_set;
	wire [1:0] unit_trig;
	wire [15:0] unit_ctrl_rd;
	wire wide_src;
	wire [2:0] wide_lim;
	wire wide_inc;
	wire per_tick;
	wire per_match;
	reg [3:0] per_lim;

	assign idx = I_PADDR[11:2];
	// Writes land at the access edge, the only edge where pready is high
	assign wr = I_PSEL & I_PENABLE & I_PWRITE & pready_q;
	assign wr_wide_low = wr & (idx == `TPC_IDX_WIDE_LOW);
	assign wr_wide_high = wr & (idx == `TPC_IDX_WIDE_HIGH);
	assign wr_wide_ctrl = wr & (idx == `TPC_IDX_WIDE_CTRL);
	assign wr_per_cnt = wr & (idx == `TPC_IDX_PER_COUNT);
	assign wr_per_ctrl = wr & (idx == `TPC_IDX_PER_CTRL);
	assign wr_unit[0] = wr & (idx == `TPC_IDX_UNIT1_CTRL);
	assign wr_unit[1] = wr & (idx == `TPC_IDX_UNIT2_CTRL);

	// Read mux and address decode, sampled in the setup cycle
	always @* begin
		prdata_d = 32'h0000_0000;
		hit_d = 1'b1;
		case (idx)
			`TPC_IDX_IRQ_FLAGS: prdata_d[7:0] = irq_flags_q;
			`TPC_IDX_UNIT2_FLAGS: prdata_d[0] = unit2_flag_q;
			`TPC_IDX_WIDE_LOW: prdata_d[7:0] = wide_cnt_q[7:0];
			`TPC_IDX_WIDE_HIGH: prdata_d[7:0] = wide_cnt_q[15:8];
			`TPC_IDX_WIDE_CTRL: prdata_d[7:0] = wide_ctrl_q;
			`TPC_IDX_PER_COUNT: prdata_d[7:0] = per_cnt_q;
			`TPC_IDX_PER_CTRL: prdata_d[7:0] = per_ctrl_q;
			`TPC_IDX_UNIT1_CTRL: prdata_d[7:0] = unit_ctrl_rd[7:0];
			`TPC_IDX_UNIT2_CTRL: prdata_d[7:0] = unit_ctrl_rd[15:8];
			`TPC_IDX_IRQ_ENABLES: prdata_d[7:0] = irq_en_q;
			`TPC_IDX_PER_LIMIT: prdata_d[7:0] = per_limit_q;
			default: hit_d = 1'b0;
		endcase
		if (I_PADDR[1:0] != 2'b00) begin
			hit_d = 1'b0;
			prdata_d = 32'h0000_0000;
		end
	end

	// APB answer: one access cycle, no wait states; unmapped gives an error
	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (I_PSEL & ~I_PENABLE) begin
			pready_q <= 1'b1;
			pslverr_q <= ~hit_d;
			prdata_q <= I_PWRITE ? 32'h0000_0000 : prdata_d;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
	end

	// Wide timer control survives ordinary resets, only power/brown-out clears it
	always @(posedge I_REF_CLK) begin
		if (I_RST & I_POR_BOR) begin
			wide_ctrl_q <= `TPC_RST_WIDE_CTRL; // RULE7
		end else if (wr_wide_ctrl) begin
			wide_ctrl_q <= I_PWDATA[7:0] & `TPC_WC_MASK;
		end
	end

	// Plain sampled edge detect; the pin is taken as synchronous to the clock
	assign wide_src = wide_ctrl_q[`TPC_WC_EXT] ? (I_WIDE_EXT_CLK & ~wide_ext_prev_q) : 1'b1;
	assign wide_lim = (3'h1 << wide_ctrl_q[`TPC_WC_PS_LO +: 2]) - 3'h1;
	assign wide_inc = wide_ctrl_q[`TPC_WC_ON] & wide_src & (wide_pre_q == wide_lim);
	assign unit_trig = I_UNIT_MATCH & unit_is_trig(unit_ctrl_rd);

	function [1:0] unit_is_trig;
		input [15:0] ctrl;
		begin
			unit_is_trig[0] = ctrl[3:0] == `TPC_UM_CMP_TRIG;
			unit_is_trig[1] = ctrl[11:8] == `TPC_UM_CMP_TRIG;
		end
	endfunction

	// Wide prescaler: cleared by any count byte write
	always @(posedge I_REF_CLK) begin
		wide_ext_prev_q <= I_WIDE_EXT_CLK;
		if (I_RST | wr_wide_low | wr_wide_high) begin
			wide_pre_q <= 3'h0; // RULE8
		end else if (wide_ctrl_q[`TPC_WC_ON] & wide_src) begin
			wide_pre_q <= (wide_pre_q == wide_lim) ? 3'h0 : wide_pre_q + 3'h1;
		end
	end

	// Wide count has no reset at all: it keeps its value through every reset
	// Priority: software write, then trigger reset, then increment
	always @(posedge I_REF_CLK) begin // RULE6
		if (wr_wide_low | wr_wide_high) begin
			if (wr_wide_low) begin
				wide_cnt_q[7:0] <= I_PWDATA[7:0]; // RULE4
			end
			if (wr_wide_high) begin
				wide_cnt_q[15:8] <= I_PWDATA[7:0]; // RULE4
			end
		end else if (|unit_trig) begin
			// Reset is applied in every mode; asynchronous mode is software's risk
			wide_cnt_q <= 16'h0000; // RULE2 RULE5
		end else if (wide_inc) begin
			wide_cnt_q <= wide_cnt_q + 16'h0001;
		end
	end

	// Period prescale limit from the select field; code 1x means 16
	always @* begin
		case (per_ctrl_q[`TPC_PC_PS_LO +: 2])
			2'b00: per_lim = `TPC_PER_PS1; // RULE10
			2'b01: per_lim = `TPC_PER_PS4; // RULE10
			default: per_lim = `TPC_PER_PS16; // RULE10
		endcase
	end

	assign per_tick = per_ctrl_q[`TPC_PC_ON] & (per_pre_q == per_lim); // RULE14
	assign per_match = per_tick & (per_cnt_q == per_limit_q);

	// Period control and limit registers
	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			per_ctrl_q <= `TPC_RST_PER_CTRL;
			per_limit_q <= `TPC_RST_PER_LIMIT; // RULE12
		end else begin
			if (wr_per_ctrl) begin
				per_ctrl_q <= I_PWDATA[7:0] & `TPC_PC_MASK;
			end
			if (wr & (idx == `TPC_IDX_PER_LIMIT)) begin
				per_limit_q <= I_PWDATA[7:0]; // RULE12
			end
		end
	end

	// Period count: a control write does not touch it
	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			per_cnt_q <= `TPC_RST_PER_COUNT; // RULE9
		end else if (wr_per_cnt) begin
			per_cnt_q <= I_PWDATA[7:0]; // RULE9 RULE16
		end else if (per_match) begin
			per_cnt_q <= 8'h00; // RULE11
		end else if (per_tick) begin
			per_cnt_q <= per_cnt_q + 8'h01; // RULE11
		end
	end

	// Pre- and postscaler counters, cleared by count or control writes
	always @(posedge I_REF_CLK) begin
		if (I_RST | wr_per_cnt | wr_per_ctrl) begin
			per_pre_q <= 4'h0; // RULE15
			per_post_q <= 4'h0; // RULE15
		end else begin
			if (per_ctrl_q[`TPC_PC_ON]) begin
				per_pre_q <= per_tick ? 4'h0 : per_pre_q + 4'h1;
			end
			if (per_match) begin
				if (per_post_q == per_ctrl_q[`TPC_PC_POST_LO +: 4]) begin
					per_post_q <= 4'h0; // RULE13
				end else begin
					per_post_q <= per_post_q + 4'h1; // RULE13
				end
			end
		end
	end

	// Match pulse to the serial port is taken before the postscaler
	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			per_match_q <= 1'b0;
		end else begin
			per_match_q <= per_match; // RULE17
		end
	end

	// Flags: hardware set wins over a software clear in the same cycle
	always @* begin
		irq_flags_d = irq_flags_q;
		if (wr & (idx == `TPC_IDX_IRQ_FLAGS)) begin
			irq_flags_d = 8'h00;
			irq_flags_d[`TPC_FL_WIDE_OVF] = I_PWDATA[`TPC_FL_WIDE_OVF];
			irq_flags_d[`TPC_FL_PERIOD] = I_PWDATA[`TPC_FL_PERIOD];
			irq_flags_d[`TPC_FL_UNIT1] = I_PWDATA[`TPC_FL_UNIT1];
		end
		// Only a real rollover sets it; a trigger reset blocks the increment
		if (wide_inc & ~(|unit_trig) & ~wr_wide_low & ~wr_wide_high &
			(wide_cnt_q == 16'hffff)) begin
			irq_flags_d[`TPC_FL_WIDE_OVF] = 1'b1; // RULE3
		end
		if (per_match & (per_post_q == per_ctrl_q[`TPC_PC_POST_LO +: 4])) begin
			irq_flags_d[`TPC_FL_PERIOD] = 1'b1; // RULE13
		end
		if (unit_set[0]) begin
			irq_flags_d[`TPC_FL_UNIT1] = 1'b1; // RULE20 RULE21
		end
	end

	// Flag and enable registers; the enables only store for software
	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			irq_flags_q <= `TPC_RST_FLAGS;
			unit2_flag_q <= 1'b0;
			irq_en_q <= `TPC_RST_FLAGS;
			adc_start_q <= 1'b0;
		end else begin
			irq_flags_q <= irq_flags_d;
			if (unit_set[1]) begin
				unit2_flag_q <= 1'b1; // RULE20 RULE21
			end else if (wr & (idx == `TPC_IDX_UNIT2_FLAGS)) begin
				unit2_flag_q <= I_PWDATA[`TPC_FL_UNIT2];
			end
			if (wr & (idx == `TPC_IDX_IRQ_ENABLES)) begin
				irq_en_q <= I_PWDATA[7:0];
			end
			adc_start_q <= unit_trig[1] & I_ADC_ENABLE; // RULE21
		end
	end

	// Two identical capture/compare mode units
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_unit
			reg [7:0] ctrl_q;
			reg [3:0] cap_pre_q;
			reg pin_prev_q;
			reg out_q;
			reg cap_q;
			reg pwm_q;
			reg [1:0] duty_q;
			wire [3:0] mode;
			wire rise;
			wire fall;
			wire is_cap;
			wire cap_evt;
			wire cmp_evt;

			assign mode = ctrl_q[3:0];
			assign rise = I_UNIT_PIN[gi] & ~pin_prev_q;
			assign fall = ~I_UNIT_PIN[gi] & pin_prev_q;
			assign is_cap = mode[3:2] == 2'b01;
			// Capture event per selected edge and scaling
			assign cap_evt = ((mode == `TPC_UM_CAP_FALL) & fall) |
				((mode == `TPC_UM_CAP_RISE) & rise) |
				((mode == `TPC_UM_CAP_RISE4) & rise & (cap_pre_q[1:0] == 2'b11)) |
				((mode == `TPC_UM_CAP_RISE16) & rise & (cap_pre_q == 4'hf)); // RULE19
			assign cmp_evt = (mode[3:2] == 2'b10) & I_UNIT_MATCH[gi]; // RULE20
			assign unit_set[gi] = cap_evt | cmp_evt;
			assign unit_ctrl_rd[gi*8 +: 8] = ctrl_q;

			always @(posedge I_REF_CLK) begin
				pin_prev_q <= I_UNIT_PIN[gi];
				if (I_RST) begin
					ctrl_q <= `TPC_RST_UNIT_CTRL;
					cap_pre_q <= 4'h0;
					out_q <= 1'b0;
					cap_q <= 1'b0;
					pwm_q <= 1'b0;
					duty_q <= 2'b00;
				end else begin
					if (wr_unit[gi]) begin
						ctrl_q <= I_PWDATA[7:0] & `TPC_UC_MASK;
					end
					// Prescaler holds zero whenever the unit is not capturing
					if (~is_cap) begin
						cap_pre_q <= 4'h0; // RULE18
					end else if (rise) begin
						cap_pre_q <= cap_pre_q + 4'h1; // RULE19
					end
					if (mode == `TPC_UM_OFF) begin
						out_q <= 1'b0; // RULE18
					end else if (I_UNIT_MATCH[gi] & (mode == `TPC_UM_CMP_SET)) begin
						out_q <= 1'b1; // RULE20
					end else if (I_UNIT_MATCH[gi] & (mode == `TPC_UM_CMP_CLR)) begin
						out_q <= 1'b0; // RULE20
					end
					cap_q <= cap_evt;
					pwm_q <= mode[3:2] == 2'b11; // RULE22
					duty_q <= (mode[3:2] == 2'b11) ? ctrl_q[5:4] : 2'b00; // RULE22
				end
			end

			assign O_UNIT_OUT[gi] = out_q;
			assign O_UNIT_CAPTURE[gi] = cap_q;
			assign O_UNIT_PWM[gi] = pwm_q;
			assign O_UNIT_DUTY_LOW[gi*2 +: 2] = duty_q;
		end
	endgenerate

	assign O_PRDATA = prdata_q;
	assign O_PREADY = pready_q;
	assign O_PSLVERR = pslverr_q;
	assign O_SEC_OSC_EN = wide_ctrl_q[`TPC_WC_OSC_EN]; // RULE1
	assign O_PERIOD_MATCH = per_match_q;
	assign O_ADC_START = adc_start_q;

endmodule // tpc_timers

// File: verification/tpc_far_side.sv
// Far-side stand-in: compare match pulses and capture pin levels
`timescale 1ns/100ps
module tpc_far_side (
	input wire i_clk,
	output reg [1:0] o_match = 2'b00,
	output reg [1:0] o_pin = 2'b00
);
	// One-cycle match, raised just after an edge
	task automatic pulse(input int u);
		begin
			o_match[u] <= 1'b1;
			@(posedge i_clk);
			o_match[u] <= 1'b0;
		end
	endtask
	// Each level held three cycles so the sampler cannot miss it
	task automatic blip(input int u);
		begin
			o_pin[u] <= 1'b1;
			repeat (3) @(posedge i_clk);
			o_pin[u] <= 1'b0;
			repeat (3) @(posedge i_clk);
		end
	endtask
endmodule // tpc_far_side

// File: verification/tpc_timers_assertions.sv
// Port-level checker for the timer block and its bind
`timescale 1ns/100ps
`include "tpc_defs.vh"
module tpc_timers_assertions (
	input wire I_REF_CLK,
	input wire I_RST,
	input wire I_POR_BOR,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [1:0] I_UNIT_PIN,
	input wire [1:0] I_UNIT_MATCH,
	input wire I_ADC_ENABLE,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY,
	input wire O_PSLVERR,
	input wire O_SEC_OSC_EN,
	input wire [1:0] O_UNIT_OUT,
	input wire [1:0] O_UNIT_CAPTURE,
	input wire O_ADC_START
);
	reg [2:0] cause_q = 3'b000;
	wire cause_d;
	// Control write or power reset may move the oscillator enable
	assign cause_d = (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY
		&& I_PADDR == {`TPC_IDX_WIDE_CTRL, 2'b00}) || (I_RST && I_POR_BOR);
	// Short history, so a late registered update is still excused
	always @(posedge I_REF_CLK) begin
		cause_q <= {cause_q[1:0], cause_d};
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);
	sequence s_setup; I_PSEL && !I_PENABLE; endsequence
	sequence s_access; I_PSEL && I_PENABLE; endsequence
	property p_ready_after_setup; s_setup |=> O_PREADY; endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
	property p_ready_cause; O_PREADY |-> s_access ##0 $past(I_PSEL && !I_PENABLE);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
	property p_ready_one; O_PREADY |=> !O_PREADY; endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready held");
	property p_err_ready; O_PSLVERR |-> O_PREADY; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_refuse_zero; O_PSLVERR |-> O_PRDATA == 32'h00000000; endproperty
	a_refuse_zero: assert property (p_refuse_zero) else $error("refused data");
	property p_osc_cause; $changed(O_SEC_OSC_EN) |-> |cause_q; endproperty
	a_osc_cause: assert property (p_osc_cause) else $error("osc moved");
	property p_adc_cause; O_ADC_START |-> $past(I_UNIT_MATCH[1] && I_ADC_ENABLE);
	endproperty
	a_adc_cause: assert property (p_adc_cause) else $error("stray start");
	property p_capture_cause; O_UNIT_CAPTURE[0] |-> $past(I_UNIT_PIN[0], 1) !=
		$past(I_UNIT_PIN[0], 2) || $past(I_UNIT_PIN[0], 2) != $past(I_UNIT_PIN[0], 3);
	endproperty
	a_capture_cause: assert property (p_capture_cause) else $error("no edge");
	property p_reset_idle; $fell(I_RST) |-> !O_PREADY && O_UNIT_OUT == 2'b00
		&& O_UNIT_CAPTURE == 2'b00 && !O_ADC_START; endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle");
endmodule // tpc_timers_assertions
bind tpc_timers tpc_timers_assertions u_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
	.I_POR_BOR(I_POR_BOR), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR), .I_UNIT_PIN(I_UNIT_PIN), .I_UNIT_MATCH(I_UNIT_MATCH),
	.I_ADC_ENABLE(I_ADC_ENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .O_SEC_OSC_EN(O_SEC_OSC_EN), .O_UNIT_OUT(O_UNIT_OUT),
	.O_UNIT_CAPTURE(O_UNIT_CAPTURE), .O_ADC_START(O_ADC_START));

// File: verification/timer_period_and_ccp_control_tb.sv
// Self-checking bench: registers, timers and unit modes over APB
`timescale 1ns/100ps
`include "tpc_defs.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
	$display("Error %s expected %0h seen %0h", n, e, s); end end
module timer_period_and_ccp_control_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg por = 1'b1;
	reg psel = 1'b0;
	reg pen = 1'b0;
	reg pwr = 1'b0;
	reg adc = 1'b0;
	reg ext = 1'b0;
	reg [11:0] addr = 12'h000;
	reg [31:0] wd = 32'h0000_0000;
	reg [7:0] rv;
	reg rerr;
	wire [31:0] rdata;
	wire rdy, err, osc, pm, go;
	wire [1:0] mt, pin, uout, cap, pwm;
	wire [3:0] duty;
	int n_fail = 0;
	int total_checks = 0;
	int n_pm = 0;
	int n_cap = 0;
	int n_adc = 0;
	int n, i, b;
	reg [9:0] ri [0:5] = '{`TPC_IDX_WIDE_CTRL, `TPC_IDX_PER_COUNT, `TPC_IDX_PER_CTRL,
		`TPC_IDX_PER_LIMIT, `TPC_IDX_IRQ_FLAGS, `TPC_IDX_UNIT1_CTRL};
	reg [7:0] rr [0:5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
	// Free-running 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end
	// Tally output pulses as the design drives them
	always @(posedge clk) begin
		n_pm <= n_pm + pm;
		n_cap <= n_cap + cap[0];
		n_adc <= n_adc + go;
	end
	tpc_timers u_dut (.I_REF_CLK(clk), .I_RST(rst), .I_POR_BOR(por), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd),
		.O_PRDATA(rdata), .O_PREADY(rdy), .O_PSLVERR(err), .I_WIDE_EXT_CLK(ext),
		.I_UNIT_PIN(pin), .I_UNIT_MATCH(mt), .I_ADC_ENABLE(adc), .O_SEC_OSC_EN(osc),
		.O_PERIOD_MATCH(pm), .O_UNIT_OUT(uout), .O_UNIT_CAPTURE(cap), .O_UNIT_PWM(pwm),
		.O_UNIT_DUTY_LOW(duty), .O_ADC_START(go));
	tpc_far_side u_far (.i_clk(clk), .o_match(mt), .o_pin(pin));
	task automatic end_of_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_fail);
			if (n_fail == 0 && total_checks > 0) begin
				$display("STATUS OK");
			end else begin
				$display("STATUS NOT OK");
			end
			$finish;
		end
	endtask
	// One APB transfer; two idle edges after it let registered outputs settle
	task automatic apb(input [9:0] idx, input w, input [7:0] d);
		int k;
		begin
			psel <= 1'b1;
			pwr <= w;
			addr <= {idx, 2'b00};
			wd <= {24'h000000, d};
			@(posedge clk);
			pen <= 1'b1;
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (rdy !== 1'b1 && k < 16);
			rv = rdata[7:0];
			rerr = err;
			psel <= 1'b0;
			pen <= 1'b0;
			`CHK("ready", 1'b1, rdy)
			// A slave that never answers ends the run here
			if (rdy !== 1'b1) end_of_test();
			repeat (2) @(posedge clk);
		end
	endtask
	// Rising edges on the external count input, each level held two cycles
	task automatic ext_rise(input int c);
		repeat (c) begin
			ext <= 1'b1;
			repeat (2) @(posedge clk);
			ext <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic wr(input [9:0] idx, input [7:0] d);
		apb(idx, 1'b1, d);
	endtask
	task automatic rd(input [9:0] idx, input [7:0] e);
		begin
			apb(idx, 1'b0, 8'h00);
			`CHK("register", e, rv)
		end
	endtask
	// Cycles from one period match to the next, bounded
	task automatic gap(output int c);
		int k, b0;
		begin
			c = 0;
			b0 = n_pm;
			for (k = 0; k < 3000 && n_pm < b0 + 2; k++) begin
				@(posedge clk);
				if (n_pm == b0 + 1) c++;
			end
			if (n_pm < b0 + 2) begin
				n_fail++;
				end_of_test();
			end
		end
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		for (i = 0; i < 6; i++) rd(ri[i], rr[i]);
		wr(`TPC_IDX_PER_CTRL, 8'hff);
		rd(`TPC_IDX_PER_CTRL, 8'h7f);
		apb(10'h001, 1'b0, 8'h00);
		`CHK("slave error", 1'b1, rerr)
		wr(`TPC_IDX_WIDE_CTRL, 8'h08);
		`CHK("osc enable", 1'b1, osc)
		// External count at 1:2; a low byte write drops the half-done prescale
		wr(`TPC_IDX_WIDE_HIGH, 8'h00);
		wr(`TPC_IDX_WIDE_CTRL, 8'h1b);
		ext_rise(1);
		wr(`TPC_IDX_WIDE_LOW, 8'h00);
		ext_rise(3);
		wr(`TPC_IDX_WIDE_CTRL, 8'h08);
		rd(`TPC_IDX_WIDE_LOW, 8'h01);
		// Stopped timer keeps its count across a control write
		wr(`TPC_IDX_PER_CTRL, 8'h00);
		wr(`TPC_IDX_PER_COUNT, 8'h05);
		wr(`TPC_IDX_PER_CTRL, 8'h78);
		repeat (20) @(posedge clk);
		rd(`TPC_IDX_PER_COUNT, 8'h05);
		// Every prescale code over a limit of three
		wr(`TPC_IDX_PER_LIMIT, 8'h03);
		for (i = 0; i < 4; i++) begin
			wr(`TPC_IDX_PER_CTRL, 8'h04 | i[7:0]);
			gap(n);
			`CHK("period", i == 0 ? 4 : i == 1 ? 16 : 64, n)
		end
		// Postscaler: flag after select plus one matches
		wr(`TPC_IDX_PER_LIMIT, 8'h0f);
		for (i = 0; i < 3; i++) begin
			wr(`TPC_IDX_PER_CTRL, 8'h00);
			wr(`TPC_IDX_PER_COUNT, 8'h00);
			wr(`TPC_IDX_IRQ_FLAGS, 8'h00);
			b = n_pm;
			wr(`TPC_IDX_PER_CTRL, {1'b0, i == 2 ? 4'hf : i[3:0], 3'b100});
			for (n = 0; n < 200 && rv[1] !== 1'b1; n++) apb(`TPC_IDX_IRQ_FLAGS, 1'b0, 8'h00);
			if (n == 200) begin
				n_fail++;
				end_of_test();
			end
			`CHK("post matches", i == 2 ? 16 : i + 1, n_pm - b)
		end
		wr(`TPC_IDX_PER_CTRL, 8'h00);
		// Compare set, clear, set, soft; each sets the unit flag
		for (i = 0; i < 4; i++) begin
			wr(`TPC_IDX_IRQ_FLAGS, 8'h00);
			wr(`TPC_IDX_UNIT1_CTRL, i == 1 ? 8'h09 : i == 3 ? 8'h0a : 8'h08);
			u_far.pulse(0);
			@(posedge clk);
			`CHK("unit out", i != 1, uout[0])
			rd(`TPC_IDX_IRQ_FLAGS, 8'h04);
		end
		wr(`TPC_IDX_UNIT1_CTRL, 8'h00);
		`CHK("unit idle", 1'b0, uout[0])
		// Trigger clears the stopped wide count, overflow flag untouched
		// All ones, so a wrap-style clear would wrongly raise the overflow flag
		wr(`TPC_IDX_WIDE_LOW, 8'hff);
		wr(`TPC_IDX_WIDE_HIGH, 8'hff);
		wr(`TPC_IDX_UNIT1_CTRL, 8'h0b);
		wr(`TPC_IDX_IRQ_FLAGS, 8'h00);
		u_far.pulse(0);
		rd(`TPC_IDX_WIDE_LOW, 8'h00);
		rd(`TPC_IDX_WIDE_HIGH, 8'h00);
		rd(`TPC_IDX_IRQ_FLAGS, 8'h04);
		// Trigger lands on the access edge of a count write
		fork
			wr(`TPC_IDX_WIDE_LOW, 8'h55);
			begin
				@(posedge clk);
				u_far.pulse(0);
			end
		join
		rd(`TPC_IDX_WIDE_LOW, 8'h55);
		adc <= 1'b1;
		wr(`TPC_IDX_UNIT2_CTRL, 8'h0b);
		b = n_adc;
		u_far.pulse(1);
		rd(`TPC_IDX_UNIT2_FLAGS, 8'h01);
		rd(`TPC_IDX_WIDE_LOW, 8'h00);
		// Converter disabled: a trigger must not start a conversion
		adc <= 1'b0;
		u_far.pulse(1);
		wr(`TPC_IDX_UNIT2_CTRL, 8'h0a);
		wr(`TPC_IDX_WIDE_LOW, 8'h55);
		u_far.pulse(1);
		rd(`TPC_IDX_WIDE_LOW, 8'h55);
		`CHK("adc starts", b + 1, n_adc)
		// Capture edge modes, unit switched off between them
		for (i = 0; i < 4; i++) begin
			wr(`TPC_IDX_UNIT1_CTRL, 8'h00);
			wr(`TPC_IDX_UNIT1_CTRL, 8'h04 + i[7:0]);
			b = n_cap;
			repeat (16) u_far.blip(0);
			repeat (4) @(posedge clk);
			`CHK("captures", i < 2 ? 16 : i == 2 ? 4 : 1, n_cap - b)
		end
		wr(`TPC_IDX_UNIT1_CTRL, 8'h3c);
		wr(`TPC_IDX_UNIT2_CTRL, 8'h2d);
		`CHK("pwm", 2'b11, pwm)
		`CHK("duty low", 4'b1011, duty)
		wr(`TPC_IDX_UNIT1_CTRL, 8'h38);
		`CHK("duty low", 4'b1000, duty)
		// Warm reset, then a power reset
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`TPC_IDX_WIDE_LOW, 8'h55);
		rd(`TPC_IDX_WIDE_CTRL, 8'h08);
		rd(`TPC_IDX_PER_LIMIT, 8'hff);
		rd(`TPC_IDX_PER_COUNT, 8'h00);
		rd(`TPC_IDX_UNIT2_CTRL, 8'h00);
		`CHK("osc enable", 1'b1, osc)
		rst <= 1'b1;
		por <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		rd(`TPC_IDX_WIDE_CTRL, 8'h00);
		`CHK("osc enable", 1'b0, osc)
		end_of_test();
	end
endmodule // timer_period_and_ccp_control_tb
